// [include/rail_supervisor_map.svh]
/*
 Register offsets, field positions, the restart key, range limits and timing counts of the rail supervisor.
 Assumes a byte-wide register port with word indices used directly as addresses.
*/
`ifndef RAIL_SUPERVISOR_MAP_SVH
`define RAIL_SUPERVISOR_MAP_SVH
`define ADDR_CH_EN_SRC_CFG 8'h00
`define ADDR_CH_EN_SERIAL 8'h01
`define ADDR_STBY_REG_CFG 8'h02
`define ADDR_CONTROL_BITS 8'h03
`define ADDR_DT_RISE_BASE 8'h04
`define ADDR_DT_FALL_BASE 8'h08
`define ADDR_UV_WARN_LEVEL 8'h0C
`define ADDR_UV_FAULT_LEVEL 8'h0D
`define ADDR_THERMAL_TRIP 8'h0E
`define ADDR_THERMAL_RESUME 8'h0F
`define ADDR_VOUT_TARGET_BASE 8'h10
`define ADDR_OV_TRIP_BASE 8'h14
`define ADDR_RESTART_CMD 8'h18
`define ADDR_VIN_READING 8'h20
`define ADDR_TJ_READING 8'h21
`define ADDR_PROT_FLAGS 8'h22
`define ADDR_WARN_FLAGS 8'h23
`define ADDR_FAULT_WARN_STATUS 8'h24
`define ADDR_VOUT_READING_BASE 8'h28
`define RESTART_KEY 8'hA5
`define CTRL_PROG_DT_BIT 0
`define CTRL_UV_AUTORESTART_BIT 1
`define CTRL_OT_AUTORESTART_BIT 2
`define CTRL_OT_MARGIN10_BIT 3
`define STBY_LEVEL5V_BIT 0
`define STBY_ON_SERIAL_BIT 1
`define STBY_ON_ENABLE_BIT 2
`define STBY_ON_GPIO_BIT 3
`define PFLAG_OTW_BIT 0
`define PFLAG_OTF_BIT 1
`define PFLAG_UVF_BIT 2
`define PFLAG_OVF_BASE 3
`define OV_STEP_LOW_MV 150
`define OV_STEP_HIGH_MV 300
`define VOUT_HIGH_RANGE_CODE 8'h32
`define BUILTIN_DT_CYCLES 8'h02
`define OC_RESTART_MS 200
`define CLK_MHZ 250
`define OC_RESTART_CYCLES (`OC_RESTART_MS * 1000 * `CLK_MHZ)
`endif

// [include/rail_supervisor_pkg.sv]
/*
 Types shared by the rail supervisor.
 Assumes the map header supplies all numbers.
*/
package rail_supervisor_pkg;
	typedef enum logic [1:0] {CHIP_OFF, CHIP_READY, CHIP_RESET} chip_state_e;
	typedef enum logic [1:0] {DRV_OFF, DRV_GAP_HIGH, DRV_HIGH, DRV_GAP_LOW} drv_state_e;
	typedef logic [7:0] byte_t;
endpackage

// [verilog/rail_supervisor.sv]
/*
 Digital supervisor of a three-rail buck controller: enable sequencing, channel enables,
 standby regulator control, dead time, and UV/OT/OV/OC fault handling.
 Assumes the analog front end delivers measured codes on the same clock and a
 PWM demand and switching-period tick per channel.
*/
`timescale 1ns/10ps
`include "rail_supervisor_map.svh"
module rail_supervisor #(
	parameter int unsigned OC_RESTART_CYCLES = `OC_RESTART_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_enable_pin,
	input wire logic [2:0] ch_gpio_pin,
	input wire logic stby_gpio_pin,
	input wire logic [2:0] nvm_default_en,
	input wire logic [2:0] nvm_src_cfg,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rail_supervisor_pkg::byte_t reg_rdata,
	input wire logic [7:0] vin_code,
	input wire logic [7:0] tj_code,
	input wire logic [23:0] vout_code,
	input wire logic [2:0] overcurrent,
	input wire logic [2:0] pwm_demand,
	input wire logic [2:0] period_tick,
	output logic device_ready_flag,
	output logic [2:0] ch_enabled,
	output logic [2:0] gate_high,
	output logic [2:0] gate_low,
	output logic builtin_nonoverlap,
	output logic stby_on,
	output logic stby_level_5v,
	output logic uv_warn_gpio
);
	import rail_supervisor_pkg::*;

	logic en_s1_q, en_s2_q, gp_s1_q, gp_s2_q;
	logic [2:0] cg_s1_q, cg_s2_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			gp_s1_q <= 1'b0;
			gp_s2_q <= 1'b0;
			cg_s1_q <= 3'h0;
			cg_s2_q <= 3'h0;
		end else begin
			en_s1_q <= chip_enable_pin;
			en_s2_q <= en_s1_q;
			gp_s1_q <= stby_gpio_pin;
			gp_s2_q <= gp_s1_q;
			cg_s1_q <= ch_gpio_pin;
			cg_s2_q <= cg_s1_q;
		end
	end

	// Soft reset drops ready and reloads the channel enable defaults; thresholds survive it
	logic restart_q;
	logic soft_rst;
	assign soft_rst = restart_q;

	chip_state_e chip_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chip_q <= CHIP_OFF;
		end else begin
			case (chip_q)
				CHIP_OFF: if (en_s2_q) chip_q <= CHIP_READY;
				CHIP_READY: begin
					if (soft_rst) chip_q <= CHIP_RESET;
					else if (!en_s2_q) chip_q <= CHIP_OFF;
				end
				CHIP_RESET: chip_q <= CHIP_OFF;
				default: chip_q <= CHIP_OFF;
			endcase
		end
	end
	logic ready;
	assign ready = (chip_q == CHIP_READY);
	// First ready cycle: loading the defaults wins over a host write
	logic ready_rise;
	assign ready_rise = ready && !device_ready_flag;
	logic clr;
	assign clr = sys_rst | soft_rst;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) device_ready_flag <= 1'b0;
		else device_ready_flag <= ready;
	end

	byte_t en_src_q, en_serial_q, stby_cfg_q, ctrl_q, uv_warn_lvl_q, uv_fault_lvl_q;
	byte_t trip_q, resume_q;
	byte_t dt_rise_q [3];
	byte_t dt_fall_q [3];
	byte_t vtarget_q [3];
	byte_t ovtrip_q [3];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_src_q <= 8'h00;
			en_serial_q <= 8'h00;
			stby_cfg_q <= 8'h00;
			ctrl_q <= 8'h00;
			uv_warn_lvl_q <= 8'h00;
			uv_fault_lvl_q <= 8'h00;
			trip_q <= 8'h7F;
			resume_q <= 8'h00;
			restart_q <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				dt_rise_q[i] <= 8'h00;
				dt_fall_q[i] <= 8'h00;
				vtarget_q[i] <= 8'h00;
				ovtrip_q[i] <= 8'h00;
			end
		end else if (soft_rst || ready_rise) begin
			// Restart and enable load the non-volatile channel defaults
			en_src_q <= {5'h00, nvm_src_cfg};
			en_serial_q <= 8'h00;
			restart_q <= 1'b0;
		end else if (reg_wr && ready) begin
			case (reg_addr)
				`ADDR_CH_EN_SRC_CFG: en_src_q <= reg_wdata;
				`ADDR_CH_EN_SERIAL: en_serial_q <= reg_wdata;
				`ADDR_STBY_REG_CFG: stby_cfg_q <= reg_wdata;
				`ADDR_CONTROL_BITS: ctrl_q <= reg_wdata;
				`ADDR_UV_WARN_LEVEL: uv_warn_lvl_q <= reg_wdata;
				`ADDR_UV_FAULT_LEVEL: uv_fault_lvl_q <= reg_wdata;
				`ADDR_THERMAL_TRIP: trip_q <= {1'b0, reg_wdata[6:0]};
				`ADDR_THERMAL_RESUME: resume_q <= {1'b0, reg_wdata[6:0]};
				`ADDR_RESTART_CMD: restart_q <= (reg_wdata == `RESTART_KEY);
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (reg_addr == `ADDR_DT_RISE_BASE + 8'(i)) dt_rise_q[i] <= reg_wdata;
						if (reg_addr == `ADDR_DT_FALL_BASE + 8'(i)) dt_fall_q[i] <= reg_wdata;
						if (reg_addr == `ADDR_VOUT_TARGET_BASE + 8'(i)) vtarget_q[i] <= reg_wdata;
						if (reg_addr == `ADDR_OV_TRIP_BASE + 8'(i)) ovtrip_q[i] <= {6'h00, reg_wdata[1:0]};
					end
				end
			endcase
		end
	end

	// UV: warn at or below warn level, fault at or below fault level
	logic uv_warn, uv_fault_q, ot_fault_q, ot_warn;
	assign uv_warn = ready && (vin_code <= uv_warn_lvl_q);
	// Temperature codes: one step = 5K, trip held in the same step units
	assign ot_warn = ready && ({1'b0, tj_code} + (ctrl_q[`CTRL_OT_MARGIN10_BIT] ? 9'd2 : 9'd1) >= {1'b0, trip_q});
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uv_fault_q <= 1'b0;
		end else if (soft_rst || !ready) begin
			uv_fault_q <= 1'b0;
		end else if (vin_code <= uv_fault_lvl_q) begin
			uv_fault_q <= 1'b1;
		end else if (vin_code > uv_warn_lvl_q && ctrl_q[`CTRL_UV_AUTORESTART_BIT]) begin
			uv_fault_q <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ot_fault_q <= 1'b0;
		end else if (soft_rst || !ready) begin
			ot_fault_q <= 1'b0;
		end else if (tj_code >= trip_q) begin
			ot_fault_q <= 1'b1;
		end else if (tj_code <= resume_q && ctrl_q[`CTRL_OT_AUTORESTART_BIT]) begin
			ot_fault_q <= 1'b0;
		end
	end
	logic global_fault;
	assign global_fault = uv_fault_q | ot_fault_q;

	logic [2:0] ov_latch_q, ov_flag_q, oc_active_q, ch_req;
	logic [31:0] oc_cnt_q [3];
	drv_state_e drv_q [3];
	logic [7:0] gap_cnt_q [3];
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_ch
			// Offset in 50mV units: 150-300mV in 50mV steps, or 300-600mV in 100mV steps above 2.5V
			logic [9:0] ov_lim;
			logic [9:0] ov_ofs;
			logic high_range;
			logic ov_hit;
			logic run;
			assign high_range = vtarget_q[g] > `VOUT_HIGH_RANGE_CODE;
			assign ov_ofs = high_range ?
				10'(`OV_STEP_HIGH_MV / 50 + 2 * ovtrip_q[g][1:0]) :
				10'(`OV_STEP_LOW_MV / 50 + ovtrip_q[g][1:0]);
			assign ov_lim = {2'b00, vtarget_q[g]} + ov_ofs;
			assign ov_hit = {2'b00, vout_code[8*g +: 8]} > ov_lim;
			assign ch_req[g] = en_src_q[g] ? cg_s2_q[g] : (nvm_default_en[g] | en_serial_q[g]);
			assign run = ready && ch_req[g] && !global_fault && !ov_latch_q[g] && !oc_active_q[g];

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ov_latch_q[g] <= 1'b0;
					ov_flag_q[g] <= 1'b0;
				end else if (soft_rst || !ready || !ch_req[g]) begin
					// Latched until the channel request drops, a soft reset comes or ready falls
					ov_latch_q[g] <= 1'b0;
					ov_flag_q[g] <= 1'b0;
				end else begin
					if (ov_hit) ov_latch_q[g] <= 1'b1;
					// Flag only once the sequencer is in DRV_OFF, where the low side may still be on
					if (ov_latch_q[g] && drv_q[g] == DRV_OFF) ov_flag_q[g] <= 1'b1;
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					oc_active_q[g] <= 1'b0;
					oc_cnt_q[g] <= 32'h0;
				end else if (soft_rst || !ready) begin
					oc_active_q[g] <= 1'b0;
					oc_cnt_q[g] <= 32'h0;
				end else if (!oc_active_q[g]) begin
					if (overcurrent[g] && ch_enabled[g]) begin
						oc_active_q[g] <= 1'b1;
						oc_cnt_q[g] <= 32'h0;
					end
				end else if (oc_cnt_q[g] == OC_RESTART_CYCLES - 1) begin
					oc_active_q[g] <= 1'b0;
				end else begin
					oc_cnt_q[g] <= oc_cnt_q[g] + 32'h1;
				end
			end

			// Non-overlap sequencer; gap counts in period/256 ticks when programmed
			logic prog_dt;
			logic gap_tick;
			logic [7:0] rise_gap;
			logic [7:0] fall_gap;
			logic [7:0] gap_next;
			assign prog_dt = ctrl_q[`CTRL_PROG_DT_BIT];
			assign gap_tick = prog_dt ? period_tick[g] : 1'b1;
			// A gap of N counts lasts N ticks; zero still costs one tick
			assign rise_gap = prog_dt ? dt_rise_q[g] : `BUILTIN_DT_CYCLES;
			assign fall_gap = prog_dt ? dt_fall_q[g] : `BUILTIN_DT_CYCLES;
			assign gap_next = gap_cnt_q[g] + 8'h01;
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					drv_q[g] <= DRV_OFF;
					gap_cnt_q[g] <= 8'h00;
					gate_high[g] <= 1'b0;
					gate_low[g] <= 1'b0;
					ch_enabled[g] <= 1'b0;
				end else if (soft_rst || !run) begin
					drv_q[g] <= DRV_OFF;
					gate_high[g] <= 1'b0;
					gate_low[g] <= 1'b0;
					ch_enabled[g] <= 1'b0;
					gap_cnt_q[g] <= 8'h00;
				end else begin
					ch_enabled[g] <= 1'b1;
					case (drv_q[g])
						DRV_OFF: begin
							drv_q[g] <= pwm_demand[g] ? DRV_GAP_HIGH : DRV_GAP_LOW;
							gap_cnt_q[g] <= 8'h00;
						end
						DRV_HIGH: if (!pwm_demand[g]) begin
							gate_high[g] <= 1'b0;
							drv_q[g] <= DRV_GAP_LOW;
							gap_cnt_q[g] <= 8'h00;
						end
						DRV_GAP_LOW: if (gap_tick) begin
							if (gap_next >= fall_gap) begin
								gate_low[g] <= 1'b1;
								drv_q[g] <= DRV_OFF;
							end else gap_cnt_q[g] <= gap_next;
						end
						DRV_GAP_HIGH: if (gap_tick) begin
							if (gap_next >= rise_gap) begin
								gate_high[g] <= 1'b1;
								drv_q[g] <= DRV_HIGH;
							end else gap_cnt_q[g] <= gap_next;
						end
						default: drv_q[g] <= DRV_OFF;
					endcase
					// Low side stays on until demand returns, then the rising gap starts
					if (drv_q[g] == DRV_OFF && gate_low[g] && !pwm_demand[g]) drv_q[g] <= DRV_OFF;
					else if (drv_q[g] == DRV_OFF && gate_low[g] && pwm_demand[g]) begin
						gate_low[g] <= 1'b0;
						drv_q[g] <= DRV_GAP_HIGH;
					end
				end
			end
		end
	endgenerate

	// Any of the three switches may hold the standby regulator on
	logic stby_req;
	assign stby_req = (stby_cfg_q[`STBY_ON_ENABLE_BIT] & en_s2_q) | (stby_cfg_q[`STBY_ON_GPIO_BIT] & gp_s2_q)
		| (stby_cfg_q[`STBY_ON_SERIAL_BIT] & ready);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			builtin_nonoverlap <= 1'b1;
			stby_on <= 1'b0;
			stby_level_5v <= 1'b0;
			uv_warn_gpio <= 1'b0;
		end else begin
			builtin_nonoverlap <= !ctrl_q[`CTRL_PROG_DT_BIT];
			stby_level_5v <= stby_cfg_q[`STBY_LEVEL5V_BIT];
			stby_on <= stby_req;
			uv_warn_gpio <= uv_warn;
		end
	end

	// Flag word built apart so the read table stays one register per line
	byte_t prot_word;
	always_comb begin
		prot_word = 8'h00;
		prot_word[`PFLAG_OTW_BIT] = ot_warn | ot_fault_q;
		prot_word[`PFLAG_OTF_BIT] = ot_fault_q;
		prot_word[`PFLAG_UVF_BIT] = uv_fault_q;
		prot_word[`PFLAG_OVF_BASE +: 3] = ov_flag_q;
	end

	// Reads answer only once ready; unmapped addresses read zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && ready && !clr) begin
			case (reg_addr)
				`ADDR_CH_EN_SRC_CFG: reg_rdata <= en_src_q;
				`ADDR_CH_EN_SERIAL: reg_rdata <= en_serial_q;
				`ADDR_STBY_REG_CFG: reg_rdata <= stby_cfg_q;
				`ADDR_CONTROL_BITS: reg_rdata <= ctrl_q;
				`ADDR_UV_WARN_LEVEL: reg_rdata <= uv_warn_lvl_q;
				`ADDR_UV_FAULT_LEVEL: reg_rdata <= uv_fault_lvl_q;
				`ADDR_THERMAL_TRIP: reg_rdata <= trip_q;
				`ADDR_THERMAL_RESUME: reg_rdata <= resume_q;
				`ADDR_VIN_READING: reg_rdata <= vin_code;
				`ADDR_TJ_READING: reg_rdata <= tj_code;
				`ADDR_PROT_FLAGS: reg_rdata <= prot_word;
				`ADDR_WARN_FLAGS: reg_rdata <= {7'h00, uv_warn};
				`ADDR_FAULT_WARN_STATUS: reg_rdata <= {4'h0, oc_active_q, uv_fault_q};
				`ADDR_VOUT_READING_BASE: reg_rdata <= vout_code[7:0];
				`ADDR_VOUT_READING_BASE + 8'h01: reg_rdata <= vout_code[15:8];
				`ADDR_VOUT_READING_BASE + 8'h02: reg_rdata <= vout_code[23:16];
				`ADDR_VOUT_TARGET_BASE: reg_rdata <= vtarget_q[0];
				`ADDR_VOUT_TARGET_BASE + 8'h01: reg_rdata <= vtarget_q[1];
				`ADDR_VOUT_TARGET_BASE + 8'h02: reg_rdata <= vtarget_q[2];
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // rail_supervisor

// [testbench/rail_supervisor_chk.sv]
/*
 Port-level checks of the rail supervisor.
 Assumes it is bound to the design top and sees one clock domain.
*/
`timescale 1ns/10ps
module rail_supervisor_chk #(
	parameter int unsigned OC_RESTART_CYCLES = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_enable_pin,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire rail_supervisor_pkg::byte_t reg_rdata,
	input wire logic [7:0] vin_code,
	input wire logic [7:0] tj_code,
	input wire logic [2:0] overcurrent,
	input wire logic device_ready_flag,
	input wire logic [2:0] ch_enabled,
	input wire logic [2:0] gate_high,
	input wire logic [2:0] gate_low
);
	import rail_supervisor_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [31:0] off_cnt_q;
	logic oc_off_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) off_cnt_q <= 32'h0;
		else if (ch_enabled[0]) off_cnt_q <= 32'h0;
		else off_cnt_q <= off_cnt_q + 32'h1;
	end
	// Remembers that channel 0 went down for overcurrent, not for another fault
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) oc_off_q <= 1'b0;
		else if (ch_enabled[0] && overcurrent[0]) oc_off_q <= 1'b1;
		else if (ch_enabled[0]) oc_off_q <= 1'b0;
	end
	property p_rd(logic [7:0] a, logic [7:0] v);
		reg_rd && reg_addr == a && device_ready_flag && !$past(reg_wr) |=> reg_rdata == $past(v);
	endproperty
	AST_GATE_EXCL: assert property ((gate_high & gate_low) == 3'h0)
		else $error("both gate drives on");
	AST_GATE_OFF: assert property ((~ch_enabled & ~$past(ch_enabled) & (gate_high | gate_low)) == 3'h0)
		else $error("gate drive on in a stopped channel");
	AST_READY_OFF: assert property (!chip_enable_pin [*6] |-> !device_ready_flag)
		else $error("ready without enable");
	AST_READY_RISE: assert property ($rose(device_ready_flag) |-> $past(chip_enable_pin, 3))
		else $error("ready rose without enable");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	AST_RD_UNMAPPED: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	AST_VIN_READ: assert property (p_rd(8'h20, vin_code))
		else $error("input voltage reading wrong");
	AST_TJ_READ: assert property (p_rd(8'h21, tj_code))
		else $error("temperature reading wrong");
	AST_OC_SHUT: assert property (overcurrent[0] && ch_enabled[0] |-> ##[1:4] !ch_enabled[0])
		else $error("overcurrent did not stop channel");
	AST_OC_HOLD: assert property ($rose(ch_enabled[0]) && oc_off_q |-> off_cnt_q >= OC_RESTART_CYCLES - 2)
		else $error("overcurrent restart too early");
	COV_READY: cover property ($rose(device_ready_flag));
	COV_OC: cover property ($rose(ch_enabled[0]) && oc_off_q);
	COV_TJ: cover property (reg_rd && reg_addr == 8'h21 && device_ready_flag);
endmodule // rail_supervisor_chk

bind rail_supervisor rail_supervisor_chk #(.OC_RESTART_CYCLES(OC_RESTART_CYCLES)) chk_u (
	.clk(clk), .sys_rst(sys_rst), .chip_enable_pin(chip_enable_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .vin_code(vin_code), .tj_code(tj_code), .overcurrent(overcurrent),
	.device_ready_flag(device_ready_flag), .ch_enabled(ch_enabled), .gate_high(gate_high), .gate_low(gate_low));

// [testbench/host_model.sv]
/*
 Host processor model on the register port.
 Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Idle cycle after a write so no strobe is assigned twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule // host_model

// [testbench/tb_rail_supervisor.sv]
/*
 Self-checking bench of the rail supervisor driven through the host model.
 Assumes the map header and package are compiled first.
*/
`timescale 1ns/10ps
`include "rail_supervisor_map.svh"
module tb_rail_supervisor;
	import rail_supervisor_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic chip_enable_pin = 1'b0;
	logic stby_gpio_pin = 1'b0;
	logic [2:0] ch_gpio_pin = 3'h4;
	logic [2:0] nvm_default_en = 3'h1;
	logic [2:0] nvm_src_cfg = 3'h4;
	logic [2:0] overcurrent = 3'h0;
	logic [2:0] pwm_demand = 3'h0;
	logic [2:0] period_tick = 3'h7;
	logic [7:0] vin_code = 8'h78;
	logic [7:0] tj_code = 8'h3C;
	logic [23:0] vout_code = 24'h000000;
	logic [7:0] reg_addr, reg_wdata, d;
	logic reg_wr, reg_rd, device_ready_flag, builtin_nonoverlap, stby_on, stby_level_5v, uv_warn_gpio;
	byte_t reg_rdata;
	logic [2:0] ch_enabled, gate_high, gate_low;
	int n_errors = 0;
	int n_compared = 0;
	int drops = 0;
	always #2 clk = ~clk;
	always @(posedge clk) pwm_demand <= {pwm_demand[1:0], ~pwm_demand[2]};
	always @(negedge device_ready_flag) if (!sys_rst) drops++;
	rail_supervisor #(.OC_RESTART_CYCLES(20)) dut_u (.clk(clk), .sys_rst(sys_rst),
		.chip_enable_pin(chip_enable_pin), .ch_gpio_pin(ch_gpio_pin), .stby_gpio_pin(stby_gpio_pin),
		.nvm_default_en(nvm_default_en), .nvm_src_cfg(nvm_src_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vin_code(vin_code), .tj_code(tj_code),
		.vout_code(vout_code), .overcurrent(overcurrent), .pwm_demand(pwm_demand), .period_tick(period_tick),
		.device_ready_flag(device_ready_flag), .ch_enabled(ch_enabled), .gate_high(gate_high),
		.gate_low(gate_low), .builtin_nonoverlap(builtin_nonoverlap), .stby_on(stby_on),
		.stby_level_5v(stby_level_5v), .uv_warn_gpio(uv_warn_gpio));
	host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		host_u.rd(a, d);
		chk($sformatf("reg %h", a), exp, d & m);
	endtask
	task automatic settle;
		repeat (10) @(posedge clk);
	endtask
	task automatic wait_ch(input logic [2:0] exp);
		for (int i = 0; i < 80 && ch_enabled !== exp; i++) @(posedge clk);
		chk("ch_enabled", {5'h00, exp}, {5'h00, ch_enabled});
	endtask
	// Edges from the low side turning off until the high side is seen on: one more than the gap
	task automatic gap_chk(input logic [7:0] exp);
		int n;
		n = 0;
		@(negedge gate_low[0]);
		while (gate_high[0] !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("rising gap", exp, 8'(n));
	endtask
	task automatic wait_rdy;
		for (int i = 0; i < 20 && device_ready_flag !== 1'b1; i++) @(posedge clk);
		chk("ready", 8'h01, {7'h00, device_ready_flag});
	endtask
	task automatic stby(input logic [7:0] c, input logic g, input logic [1:0] e);
		stby_gpio_pin <= g;
		host_u.wr(`ADDR_STBY_REG_CFG, c);
		settle;
		chk("stby", {6'h00, e}, {6'h00, stby_on, stby_level_5v});
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("nonoverlap", 8'h01, {7'h00, builtin_nonoverlap});
		rchk(`ADDR_VIN_READING, 8'hFF, 8'h00);
		chip_enable_pin <= 1'b1;
		wait_rdy;
		wait_ch(3'h5);
		rchk(`ADDR_VIN_READING, 8'hFF, 8'h78);
		rchk(`ADDR_TJ_READING, 8'hFF, 8'h3C);
		rchk(8'h30, 8'hFF, 8'h00);
		host_u.wr(`ADDR_CH_EN_SERIAL, 8'h02);
		wait_ch(3'h7);
		ch_gpio_pin <= 3'h0;
		wait_ch(3'h3);
		ch_gpio_pin <= 3'h4;
		wait_ch(3'h7);
		$display("test enable done");
		host_u.wr(`ADDR_VOUT_TARGET_BASE, 8'h32);
		host_u.wr(`ADDR_VOUT_TARGET_BASE + 8'h1, 8'h14);
		host_u.wr(`ADDR_VOUT_TARGET_BASE + 8'h2, 8'h14);
		rchk(`ADDR_VOUT_TARGET_BASE, 8'hFF, 8'h32);
		host_u.wr(`ADDR_OV_TRIP_BASE, 8'h03);
		host_u.wr(`ADDR_OV_TRIP_BASE + 8'h1, 8'h01);
		host_u.wr(`ADDR_OV_TRIP_BASE + 8'h2, 8'h00);
		vout_code <= 24'h191838;
		wait_ch(3'h3);
		rchk(`ADDR_PROT_FLAGS, 8'h38, 8'h20);
		rchk(`ADDR_VOUT_READING_BASE + 8'h1, 8'hFF, 8'h18);
		vout_code <= 24'h141432;
		ch_gpio_pin <= 3'h0;
		settle;
		ch_gpio_pin <= 3'h4;
		wait_ch(3'h7);
		$display("test overvoltage done");
		gap_chk(8'h03);
		host_u.wr(`ADDR_DT_RISE_BASE, 8'h03);
		host_u.wr(`ADDR_DT_FALL_BASE, 8'h03);
		host_u.wr(`ADDR_CONTROL_BITS, 8'h01);
		settle;
		chk("nonoverlap", 8'h00, {7'h00, builtin_nonoverlap});
		gap_chk(8'h04);
		stby(8'h09, 1'b1, 2'h3);
		stby(8'h09, 1'b0, 2'h1);
		stby(8'h02, 1'b0, 2'h2);
		stby(8'h04, 1'b0, 2'h2);
		$display("test standby done");
		host_u.wr(`ADDR_UV_WARN_LEVEL, 8'h64);
		host_u.wr(`ADDR_UV_FAULT_LEVEL, 8'h50);
		host_u.wr(`ADDR_CONTROL_BITS, 8'h03);
		vin_code <= 8'h5A;
		settle;
		chk("uv_warn_gpio", 8'h01, {7'h00, uv_warn_gpio});
		rchk(`ADDR_WARN_FLAGS, 8'h01, 8'h01);
		vin_code <= 8'h46;
		wait_ch(3'h0);
		rchk(`ADDR_FAULT_WARN_STATUS, 8'h01, 8'h01);
		chk("gates", 8'h00, {2'h0, gate_high, gate_low});
		vin_code <= 8'h5A;
		settle;
		chk("ch_enabled", 8'h00, {5'h00, ch_enabled});
		vin_code <= 8'h78;
		wait_ch(3'h7);
		$display("test undervoltage done");
		host_u.wr(`ADDR_THERMAL_TRIP, 8'h40);
		host_u.wr(`ADDR_THERMAL_RESUME, 8'h30);
		host_u.wr(`ADDR_CONTROL_BITS, 8'h05);
		tj_code <= 8'h3E;
		settle;
		rchk(`ADDR_PROT_FLAGS, 8'h01, 8'h00);
		host_u.wr(`ADDR_CONTROL_BITS, 8'h0D);
		settle;
		rchk(`ADDR_PROT_FLAGS, 8'h01, 8'h01);
		tj_code <= 8'h41;
		wait_ch(3'h0);
		rchk(`ADDR_PROT_FLAGS, 8'h03, 8'h03);
		tj_code <= 8'h35;
		settle;
		chk("ch_enabled", 8'h00, {5'h00, ch_enabled});
		tj_code <= 8'h2F;
		wait_ch(3'h7);
		$display("test temperature done");
		overcurrent <= 3'h1;
		wait_ch(3'h6);
		rchk(`ADDR_FAULT_WARN_STATUS, 8'h02, 8'h02);
		overcurrent <= 3'h0;
		wait_ch(3'h7);
		$display("test overcurrent done");
		host_u.wr(`ADDR_RESTART_CMD, `RESTART_KEY);
		settle;
		wait_rdy;
		chk("ready drops", 8'h01, drops[7:0]);
		wait_ch(3'h5);
		chip_enable_pin <= 1'b0;
		wait_ch(3'h0);
		chk("ready", 8'h00, {7'h00, device_ready_flag});
		$display("test reset done");
		final_report;
	end
endmodule // tb_rail_supervisor
